/* hw/i2c_frame_pkg.sv */
// Package with constants and carrier types for the I2C target address framing block.
package i2c_frame_pkg;
   localparam int          BYTE_BITS    = 8;        // Bits per byte on the link.
   localparam int          REG_AW       = 10;       // Register address width.
   localparam logic [2:0]  OWN_PREFIX   = 3'h5;     // Upper chip-address bits 1,0,1.
   localparam logic [4:0]  BCAST_ADDR   = 5'h1b;    // Broadcast chip address 1,1,0,1,1.
   localparam int          CHIP_MSB     = 7;        // Chip address field top bit.
   localparam int          CHIP_LSB     = 3;        // Chip address field low bit.
   localparam int          RHI_MSB      = 2;        // Register address bits 9..8 field top.
   localparam int          RHI_LSB      = 1;        // Register address bits 9..8 field low.
   localparam int          RW_BIT       = 0;        // Direction flag position, 1 is read.
   localparam logic [3:0]  ACK_COUNT    = 4'h8;     // Bit count at which the ack slot starts.

   // Phases of a transfer as seen by the target.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_ADDR1 = 3'b001,
      ST_ADDR2 = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100,
      ST_SKIP  = 3'b101
   } frame_state_e;

   // Register access request toward the register file.
   typedef struct packed {
      logic              wr;      // One-cycle write strobe.
      logic              rd;      // One-cycle read fetch strobe.
      logic [REG_AW-1:0] addr;    // Register address.
      logic [7:0]        wdata;   // Write data.
   } reg_req_s;
endpackage

/* hw/i2c_target_framing.sv */
// I2C target that frames chip address, register address and data bytes.
`timescale 1ns/1ps
`default_nettype none
module i2c_target_framing (
   input  wire logic                    sys_clk,     // System clock, 25 MHz.
   input  wire logic                    rst_n,       // Synchronous reset, active low.
   input  wire logic                    clk_en,      // Freezes all state while low.
   input  wire logic [1:0]              variant_id,  // Variant chip-address bits 1 and 0.
   input  wire logic                    scl_i,       // Clock line level.
   input  wire logic                    sda_i,       // Data line level.
   output logic                         sda_o,       // Data line drive value, always low.
   output logic                         sda_oe,      // High while pulling the data line low.
   output i2c_frame_pkg::reg_req_s      req,         // Register access request.
   input  wire logic [7:0]              rd_data      // Read data, valid the cycle after rd.
);
   import i2c_frame_pkg::*;

   logic [1:0]   scl_sync_q;     // Two-stage synchroniser for the clock line.
   logic [1:0]   sda_sync_q;     // Two-stage synchroniser for the data line.
   logic         scl_prev_q;     // Previous synchronised clock level.
   logic         sda_prev_q;     // Previous synchronised data level.
   frame_state_e state_q;        // Transfer phase.
   logic [3:0]   bit_cnt_q;      // Bits shifted in the current byte.
   logic [7:0]   shift_q;        // Received byte being assembled.
   logic [7:0]   tx_q;           // Byte being sent on reads.
   logic [REG_AW-1:0] addr_q;    // Running register address.
   logic [1:0]   addr_hi_q;      // High address bits held from the first byte.
   logic         ack_q;          // Drive acknowledge in the ninth slot.
   logic         tx_on_q;        // Drive read data bits.
   logic         rd_fetch_q;     // Read data arrives this cycle.
   logic         master_nak_q;   // Controller left acknowledge high.
   logic         rd_hdr_q;       // Read header received, its ninth slot is still ours.
   reg_req_s     req_q;          // Registered request.

   logic scl, sda, scl_rise, scl_fall, start_c, stop_c, byte_done;
   logic [7:0] rx_byte;

   // Chip address match for own or broadcast address.
   function automatic logic chip_match(input logic [7:0] b, input logic [1:0] v);
      chip_match = (b[CHIP_MSB:CHIP_LSB] == {OWN_PREFIX, v}) ||
                   (b[CHIP_MSB:CHIP_LSB] == BCAST_ADDR);
   endfunction

   // Pin inputs are asynchronous, so each passes two flops before use.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (clk_en) begin
         scl_sync_q <= {scl_sync_q[0], scl_i};
         sda_sync_q <= {sda_sync_q[0], sda_i};
         scl_prev_q <= scl_sync_q[1];
         sda_prev_q <= sda_sync_q[1];
      end
   end

   assign scl       = scl_sync_q[1];
   assign sda       = sda_sync_q[1];
   assign scl_rise  = clk_en && scl && !scl_prev_q;
   assign scl_fall  = clk_en && !scl && scl_prev_q;
   assign start_c   = clk_en && scl && scl_prev_q && sda_prev_q && !sda;
   assign stop_c    = clk_en && scl && scl_prev_q && !sda_prev_q && sda;
   // A byte is complete once the eighth bit is sampled.
   assign byte_done = scl_rise && (bit_cnt_q == ACK_COUNT - 4'h1);
   assign rx_byte   = {shift_q[6:0], sda};

   // Bit counter and shift register; a count of 8 marks the acknowledge slot.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
      end else if (start_c || stop_c) begin
         bit_cnt_q <= 4'h0;
      end else if (scl_rise && bit_cnt_q < ACK_COUNT) begin
         shift_q   <= rx_byte;
         bit_cnt_q <= bit_cnt_q + 4'h1;
      end else if (scl_fall && bit_cnt_q == ACK_COUNT + 4'h1) begin
         bit_cnt_q <= 4'h0;
      end else if (scl_rise && bit_cnt_q == ACK_COUNT) begin
         bit_cnt_q <= ACK_COUNT + 4'h1;
      end
   end

   // Master acknowledge sampled in the ninth slot of a read byte.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         master_nak_q <= 1'b0;
      end else if (start_c || stop_c) begin
         master_nak_q <= 1'b0;
      end else if (scl_rise && bit_cnt_q == ACK_COUNT && state_q == ST_RDATA) begin
         master_nak_q <= sda;
      end
   end

   // The read header is a received byte, so its ninth slot is acknowledged too; the flag
   // also keeps that slot from being taken as the controller's acknowledge of data.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rd_hdr_q <= 1'b0;
      end else if (start_c || stop_c) begin
         rd_hdr_q <= 1'b0;
      end else if (byte_done && state_q == ST_ADDR1 && rx_byte[RW_BIT] &&
                   chip_match(rx_byte, variant_id)) begin
         rd_hdr_q <= 1'b1;
      end else if (scl_fall && bit_cnt_q == ACK_COUNT + 4'h1) begin
         // The slot ends at this fall, so the next ninth slot belongs to the controller.
         rd_hdr_q <= 1'b0;
      end
   end

   // Framing state machine, address tracking and register requests.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_q    <= ST_IDLE;
         addr_q     <= '0;
         addr_hi_q  <= 2'h0;
         req_q      <= '0;
         rd_fetch_q <= 1'b0;
      end else if (clk_en) begin
         req_q.wr   <= 1'b0;
         req_q.rd   <= 1'b0;
         rd_fetch_q <= req_q.rd;
         if (stop_c) begin
            state_q <= ST_IDLE;
         end else if (start_c) begin
            // A repeated start also begins a fresh first byte.
            state_q <= ST_ADDR1;
         end else if (byte_done) begin
            case (state_q)
               ST_ADDR1: begin
                  if (!chip_match(rx_byte, variant_id)) begin
                     state_q <= ST_SKIP;
                  end else if (rx_byte[RW_BIT]) begin
                     // Read continues from the address set by the write phase.
                     state_q  <= ST_RDATA;
                     req_q.rd <= 1'b1;
                     req_q.addr <= addr_q;
                  end else begin
                     addr_hi_q <= rx_byte[RHI_MSB:RHI_LSB];
                     state_q   <= ST_ADDR2;
                  end
               end
               ST_ADDR2: begin
                  addr_q  <= {addr_hi_q, rx_byte};
                  state_q <= ST_WDATA;
               end
               ST_WDATA: begin
                  req_q.wr    <= 1'b1;
                  req_q.addr  <= addr_q;
                  req_q.wdata <= rx_byte;
                  addr_q      <= addr_q + 1'b1;
               end
               default: begin
                  state_q <= state_q;
               end
            endcase
         end else if (state_q == ST_RDATA && scl_rise && bit_cnt_q == ACK_COUNT &&
                      !rd_hdr_q) begin
            // Each byte sent advances the address; an acknowledge prefetches the next one.
            addr_q <= addr_q + 1'b1;
            if (sda) begin
               state_q <= ST_SKIP;
            end else begin
               req_q.rd   <= 1'b1;
               req_q.addr <= addr_q + 1'b1;
            end
         end
      end
   end

   // Read data shifter; the first bit is driven after the ack slot ends.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tx_q    <= 8'hff;
         tx_on_q <= 1'b0;
      end else if (start_c || stop_c) begin
         tx_on_q <= 1'b0;
      end else if (clk_en && rd_fetch_q) begin
         // Gated so a frozen cycle cannot reload the byte from a moving input.
         tx_q <= rd_data;
      end else if (scl_fall && state_q == ST_RDATA && !master_nak_q) begin
         if (bit_cnt_q == ACK_COUNT + 4'h1 || bit_cnt_q == 4'h0) begin
            tx_on_q <= 1'b1;
         end else if (bit_cnt_q < ACK_COUNT) begin
            tx_q <= {tx_q[6:0], 1'b1};
            tx_on_q <= (bit_cnt_q != ACK_COUNT);
         end
         if (bit_cnt_q == ACK_COUNT) begin
            tx_on_q <= 1'b0;
         end
      end
   end

   // Acknowledge drive from the falling edge after bit eight to the next fall.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else if (start_c || stop_c) begin
         ack_q <= 1'b0;
      end else if (scl_fall && bit_cnt_q == ACK_COUNT) begin
         // Received bytes are the address bytes and write data only.
         // Data bytes sent on a read are acknowledged by the controller, not by us.
         ack_q <= (state_q == ST_ADDR2) || (state_q == ST_WDATA) || rd_hdr_q;
      end else if (scl_fall) begin
         ack_q <= 1'b0;
      end
   end

   // Open-drain drive: low for acknowledge or a zero data bit.
   assign sda_o  = 1'b0;
   assign sda_oe = ack_q || (tx_on_q && !tx_q[7]);
   assign req    = req_q;
endmodule // i2c_target_framing
`default_nettype wire

/* tb/i2c_target_framing_props.sv */
// Port checker for the I2C target framing block, bound to every instance.
`timescale 1ns/1ps
`default_nettype none
module i2c_target_framing_props (
   input wire logic                 sys_clk,
   input wire logic                 rst_n,
   input wire logic                 clk_en,
   input wire logic [1:0]           variant_id,
   input wire logic                 scl_i,
   input wire logic                 sda_i,
   input wire logic                 sda_o,
   input wire logic                 sda_oe,
   input wire i2c_frame_pkg::reg_req_s req,
   input wire logic [7:0]           rd_data
);
   import i2c_frame_pkg::*;
   localparam int OE_MAX = 200;  // An acknowledge and eight zero bits at the bench rate, with margin.
   int unsigned oe_run_q;        // Enabled cycles the data line has been held low.
   // A stuck drive would hang the bus, so the run of low cycles is counted.
   always_ff @(posedge sys_clk) begin
      if (!rst_n || !sda_oe) oe_run_q <= 0;
      else if (clk_en) oe_run_q <= oe_run_q + 1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet; !sda_oe && (req == '0); endsequence
   sequence s_held; $stable(sda_oe) && $stable(req); endsequence
   property p_reset; disable iff (1'b0) !rst_n |=> s_quiet; endproperty
   a_drive_low_only: assert property (sda_o == 1'b0) else $error("drive value not low");
   a_wr_pulse: assert property (req.wr && clk_en |=> !req.wr) else $error("long write");
   a_rd_pulse: assert property (req.rd && clk_en |=> !req.rd) else $error("long read");
   a_one_strobe: assert property (!(req.wr && req.rd)) else $error("both strobes");
   a_reset_quiet: assert property (p_reset) else $error("outputs busy in reset");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i) else $error("drive moved");
   a_oe_bounded: assert property (oe_run_q <= OE_MAX) else $error("data held low too long");
   a_freeze_hold: assert property (!clk_en |=> s_held) else $error("state moved while frozen");
endmodule // i2c_target_framing_props
bind i2c_target_framing i2c_target_framing_props i2c_target_framing_props_i (.sys_clk, .rst_n,
   .clk_en, .variant_id, .scl_i, .sda_i, .sda_o, .sda_oe, .req, .rd_data);
`default_nettype wire

/* tb/i2c_ctl_model.sv */
// Bus controller model that drives the clock line and its share of the data line.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctl_model #(parameter int HALF = 8) (
   input  wire logic sys_clk,    // Bench clock.
   input  wire logic sda_line,   // Resolved data line, pulled up when released.
   output var logic  scl_q,      // Clock line; stands high between frames.
   output var logic  sda_low_q   // High while the controller pulls data low.
);
   initial begin
      scl_q = 1'b1;
      sda_low_q = 1'b0;
   end
   // Half a bus clock period in system cycles.
   task automatic wt();
      repeat (HALF) @(posedge sys_clk);
   endtask
   // One bit; data moves a cycle after the clock falls so it never looks like a start or stop.
   task automatic bit_x(input logic b, output logic s);
      @(posedge sys_clk);
      sda_low_q <= !b;
      wt();
      scl_q <= 1'b1;
      wt();
      s = sda_line;
      scl_q <= 1'b0;
   endtask
   // Start, also used as repeated start.
   task automatic start();
      sda_low_q <= 1'b0;
      wt();
      scl_q <= 1'b1;
      wt();
      sda_low_q <= 1'b1;
      wt();
      scl_q <= 1'b0;
   endtask
   // Stop leaves both lines released.
   task automatic stop();
      sda_low_q <= 1'b1;
      wt();
      scl_q <= 1'b1;
      wt();
      sda_low_q <= 1'b0;
      wt();
   endtask
   // Eight bits out MSB first, then the ack slot; a read sends all ones and samples.
   task automatic xb(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                     output logic ack);
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ack_in, ack);
   endtask
endmodule // i2c_ctl_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the I2C target framing block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import i2c_frame_pkg::*;
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
   logic        sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1;  // Clock, reset and freeze.
   logic [1:0]  variant_id = 2'h0;                            // Variant chip-address bits.
   logic [7:0]  rd_data = 8'h00, q;                           // Read data and received byte.
   logic        sda_o, sda_oe, scl, ctl_low, a;               // Bus wiring and ack seen.
   logic [9:0]  ptr;                                          // Expected register pointer.
   logic [18:0] e, exp_q[$];                                  // Expected {rd, addr, data}.
   reg_req_s    req;                                          // Request from the design.
   wire logic   sda_line = !(ctl_low || sda_oe);              // Pull-up resolution.
   int          error_cnt = 0, n_checks = 0;
   i2c_target_framing i2c_target_framing_i (.sys_clk, .rst_n, .clk_en, .variant_id,
      .scl_i(scl), .sda_i(sda_line), .sda_o, .sda_oe, .req, .rd_data);
   i2c_ctl_model i2c_ctl_model_i (.sys_clk, .sda_line, .scl_q(scl), .sda_low_q(ctl_low));
   initial forever #20 sys_clk = ~sys_clk;
   // Register file stand-in and request scoreboard; reads return address xor a pattern.
   always @(posedge sys_clk) begin
      rd_data <= req.addr[7:0] ^ 8'h5a;
      if (req.wr || req.rd) begin
         e = exp_q.size() ? exp_q.pop_front() : 19'h7ffff;
         `CHK("req", e, {req.rd, req.addr, e[18] ? 8'h00 : req.wdata})
      end
   end
   // Address bytes, the second only after a hit; only a matching chip address is acknowledged.
   task automatic open_tx(input logic [4:0] chip, input logic [9:0] ra, input logic hit);
      i2c_ctl_model_i.start();
      i2c_ctl_model_i.xb({chip, ra[9:8], 1'b0}, 1'b1, q, a);
      `CHK("ack1", !hit, a)
      if (hit) begin
         i2c_ctl_model_i.xb(ra[7:0], 1'b1, q, a);
         `CHK("ack2", 1'b0, a)
         ptr = ra;
      end
   endtask
   // One data byte written at the running pointer.
   task automatic wr(input logic [7:0] d);
      exp_q.push_back({1'b0, ptr, d});
      i2c_ctl_model_i.xb(d, 1'b1, q, a);
      `CHK("ackd", 1'b0, a)
      ptr = ptr + 10'h1;
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard, several times the expected run length.
   initial begin
      repeat (60000) @(posedge sys_clk);
      error_cnt++;
      close_out();
   end
   initial begin
      void'($urandom(32'h39d202b9));
      variant_id = 2'($urandom);
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Random freezing while the bus is idle.
      repeat (30) @(posedge sys_clk) clk_en <= 1'($urandom);
      @(posedge sys_clk) clk_en <= 1'b1;
      for (int c = 0; c < 32; c++) begin
         open_tx(5'(c), 10'h0, 5'(c) == {OWN_PREFIX, variant_id} || 5'(c) == BCAST_ADDR);
         i2c_ctl_model_i.stop();
      end
      open_tx({OWN_PREFIX, variant_id}, 10'($urandom), 1'b1);
      repeat (3) wr(8'($urandom));
      i2c_ctl_model_i.stop();
      // Broadcast burst across the top of the address space.
      open_tx(BCAST_ADDR, 10'h3fe, 1'b1);
      repeat (3) wr(8'($urandom));
      i2c_ctl_model_i.stop();
      open_tx({OWN_PREFIX, variant_id}, 10'($urandom), 1'b1);
      i2c_ctl_model_i.start();
      // The header fetch and each acknowledged byte's prefetch come before that byte's slot.
      exp_q.push_back({1'b1, ptr, 8'h00});
      i2c_ctl_model_i.xb({OWN_PREFIX, variant_id, 3'h1}, 1'b1, q, a);
      `CHK("ackr", 1'b0, a)
      for (int k = 0; k < 3; k++) begin
         if (k < 2) exp_q.push_back({1'b1, ptr + 10'h1, 8'h00});
         i2c_ctl_model_i.xb(8'hff, k == 2, q, a);
         `CHK("rdat", ptr[7:0] ^ 8'h5a, q)
         ptr = ptr + 10'h1;
      end
      i2c_ctl_model_i.stop();
      repeat (10) @(posedge sys_clk);
      `CHK("left", 0, exp_q.size())
      close_out();
   end
endmodule // tb_top
`default_nettype wire
